// >>> mmw_defs.svh
// Constants of the module management two-wire target: addresses, map layout, reset values
`ifndef MMW_DEFS_SVH
`define MMW_DEFS_SVH

`define MMW_TGT_ADDR      7'h50
`define MMW_MAP_BYTES     640
`define MMW_PAGE_SEL_ADDR 8'h7f
`define MMW_LOW_WR_FIRST  8'h56
`define MMW_FLAG_TEMP     8'h06
`define MMW_FLAG_VCC      8'h07
`define MMW_MON_TEMP      8'h16
`define MMW_MON_VCC       8'h1a
`define MMW_MON_RXP       8'h22
`define MMW_MON_BIAS      8'h2a
`define MMW_MON_TXP       8'h32
`define MMW_THR_TEMP      8'h80
`define MMW_THR_VCC       8'h90
`define MMW_PAGE_RST      8'h00
`define MMW_FILL_BYTE     8'h00
`define MMW_TEMP_HI_ALM   16'h4b00
`define MMW_TEMP_LO_ALM   16'hfb00
`define MMW_TEMP_HI_WRN   16'h4600
`define MMW_TEMP_LO_WRN   16'h0000
`define MMW_VCC_HI_ALM    16'h8ca0
`define MMW_VCC_LO_ALM    16'h7530
`define MMW_VCC_HI_WRN    16'h88b8
`define MMW_VCC_LO_WRN    16'h7918

`endif

// >>> mmw_pkg.sv
// Types of the module management two-wire target
package mmw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_WRITE  = 3'b010,
        ST_READ   = 3'b011,
        ST_IGNORE = 3'b100
    } mmw_state_e;
endpackage

// >>> mmw_target.sv
// Two-wire management target with paged memory map, live monitors and alarm flags
`timescale 1ns/1ps
`include "mmw_defs.svh"

// What this block does
// - Sample data on rising edge; protect regions
// - Change returned data bit on falling edge
// - Bidirectional data; start and stop frame transfers
// - Memory is bytes, single or sequential access
// - Random and sequential access from 00h upward
// - Fixed 128-byte lower page plus paged upper
// - Page select chooses the upper page
// - Lower page, upper pages 00, 03 always
// - Optional page 01 table, page 02 storage
// - Answer at target address A0h only
// - Attention low on flags; host reads them
// - Live temperature, bias, powers, supply readable
// - Alarm and warning flags on range exit
module mmw_target #(
    parameter bit HAS_PAGE1 = 1'b1,
    parameter bit HAS_PAGE2 = 1'b1
) (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        LINK_SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic [15:0] TEMP_MON,
    input  wire logic [15:0] VCC_MON,
    input  wire logic [63:0] RX_POWER,
    input  wire logic [63:0] TX_BIAS,
    input  wire logic [63:0] TX_POWER,
    output logic             ATTENTION_N
);

    function automatic logic [9:0] mem_index(input logic [7:0] pg, input logic [7:0] a);
        if (!a[7]) begin
            return {3'b000, a[6:0]};
        end
        return {3'(pg[1:0]) + 3'd1, a[6:0]};
    endfunction

    function automatic logic page_present(input logic [7:0] pg);
        return (pg == 8'h00) || (pg == 8'h03) ||
               (pg == 8'h01 && HAS_PAGE1) || (pg == 8'h02 && HAS_PAGE2);
    endfunction

    // Byte of a four-lane, 16-bit-per-lane monitor vector, most significant byte first
    function automatic logic [7:0] lane_byte(input logic [63:0] v, input logic [7:0] off);
        return v[{off[2:1], ~off[0], 3'b000} +: 8];
    endfunction

    localparam logic [9:0] THR_T = mem_index(8'h03, `MMW_THR_TEMP);
    localparam logic [9:0] THR_V = mem_index(8'h03, `MMW_THR_VCC);

    // Link side: runs only on the host's serial clock
    logic [7:0] link_sh_q;
    logic       sda_oe_q;
    logic       drive_low_q;

    always_ff @(posedge LINK_SCL) begin
        link_sh_q <= {link_sh_q[6:0], SDA_IN};
    end

    always_ff @(negedge LINK_SCL) begin
        sda_oe_q <= drive_low_q;
    end

    // System side
    logic       scl_s1_q, scl_s2_q, scl_s3_q;
    logic       sda_s1_q, sda_s2_q, sda_s3_q;
    logic       oe_hold_q;
    logic       rw_q;
    logic       have_ptr_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] ptr_q;
    logic [7:0] page_q;
    logic [7:0] tx_q;
    logic [7:0] flag_q;
    logic       attn_n_q;
    logic [7:0] mem [0:`MMW_MAP_BYTES-1];
    mmw_pkg::mmw_state_e state_q;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= LINK_SCL;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= SDA_IN;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    wire scl_rise = scl_s2_q & ~scl_s3_q;
    wire scl_fall = ~scl_s2_q & scl_s3_q;
    wire scl_high = scl_s2_q & scl_s3_q;
    wire bus_start = scl_high & sda_s3_q & ~sda_s2_q;
    wire bus_stop  = scl_high & ~sda_s3_q & sda_s2_q;

    // The link shift register is settled for the whole high phase when the rise is seen here
    wire [7:0] rx_byte  = link_sh_q;
    wire       byte_end = scl_rise && bit_cnt_q == 4'd7;
    wire       ack_end  = scl_rise && bit_cnt_q == 4'd8;
    wire       addr_hit = rx_byte[7:1] == `MMW_TGT_ADDR;

    // Read data: page select, flags, live monitors, then the stored map
    wire [7:0] off_rx   = ptr_q - `MMW_MON_RXP;
    wire [7:0] off_bias = ptr_q - `MMW_MON_BIAS;
    wire [7:0] off_tx   = ptr_q - `MMW_MON_TXP;
    wire       upper    = ptr_q[7];
    wire       absent   = upper && !page_present(page_q);
    wire [7:0] rd_byte  =
        (ptr_q == `MMW_PAGE_SEL_ADDR)           ? page_q :
        (ptr_q == `MMW_FLAG_TEMP)               ? {flag_q[7:4], 4'h0} :
        (ptr_q == `MMW_FLAG_VCC)                ? {flag_q[3:0], 4'h0} :
        (ptr_q == `MMW_MON_TEMP)                ? TEMP_MON[15:8] :
        (ptr_q == `MMW_MON_TEMP + 8'h01)        ? TEMP_MON[7:0] :
        (ptr_q == `MMW_MON_VCC)                 ? VCC_MON[15:8] :
        (ptr_q == `MMW_MON_VCC + 8'h01)         ? VCC_MON[7:0] :
        (off_rx < 8'h08)                        ? lane_byte(RX_POWER, off_rx) :
        (off_bias < 8'h08)                      ? lane_byte(TX_BIAS, off_bias) :
        (off_tx < 8'h08)                        ? lane_byte(TX_POWER, off_tx) :
        absent                                  ? `MMW_FILL_BYTE :
                                                  mem[mem_index(page_q, ptr_q)];

    wire rd_load = ack_end && ((state_q == mmw_pkg::ST_ADDR && rw_q) ||
                   (state_q == mmw_pkg::ST_READ && !rx_byte[0]));
    wire wr_data = byte_end && state_q == mmw_pkg::ST_WRITE && have_ptr_q;
    // Lower page control area and user page 02 only; identity and thresholds stay fixed
    wire wr_ok = (!upper && ptr_q >= `MMW_LOW_WR_FIRST) ||
                 (upper && page_q == 8'h02 && HAS_PAGE2);
    wire mem_we = wr_data && wr_ok && ptr_q != `MMW_PAGE_SEL_ADDR;
    wire pg_we  = wr_data && ptr_q == `MMW_PAGE_SEL_ADDR;

    // Range checks against thresholds held in upper page 03
    wire [15:0] t_ha = {mem[THR_T],         mem[THR_T + 10'd1]};
    wire [15:0] t_la = {mem[THR_T + 10'd2], mem[THR_T + 10'd3]};
    wire [15:0] t_hw = {mem[THR_T + 10'd4], mem[THR_T + 10'd5]};
    wire [15:0] t_lw = {mem[THR_T + 10'd6], mem[THR_T + 10'd7]};
    wire [15:0] v_ha = {mem[THR_V],         mem[THR_V + 10'd1]};
    wire [15:0] v_la = {mem[THR_V + 10'd2], mem[THR_V + 10'd3]};
    wire [15:0] v_hw = {mem[THR_V + 10'd4], mem[THR_V + 10'd5]};
    wire [15:0] v_lw = {mem[THR_V + 10'd6], mem[THR_V + 10'd7]};
    wire [7:0] flag_set = {
        $signed(TEMP_MON) > $signed(t_ha), $signed(TEMP_MON) < $signed(t_la),
        $signed(TEMP_MON) > $signed(t_hw), $signed(TEMP_MON) < $signed(t_lw),
        VCC_MON > v_ha, VCC_MON < v_la, VCC_MON > v_hw, VCC_MON < v_lw};
    // Flags clear when their byte is read out; a new event in that cycle survives
    wire [7:0] flag_clr = {{4{rd_load && ptr_q == `MMW_FLAG_TEMP}},
                           {4{rd_load && ptr_q == `MMW_FLAG_VCC}}};
    wire [7:0] flag_d   = (flag_q & ~flag_clr) | flag_set;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            flag_q   <= 8'h00;
            attn_n_q <= 1'b1;
        end else begin
            flag_q   <= flag_d;
            attn_n_q <= ~|flag_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            for (int i = 0; i < `MMW_MAP_BYTES; i++) begin
                mem[i] <= 8'h00;
            end
            {mem[THR_T],         mem[THR_T + 10'd1]} <= `MMW_TEMP_HI_ALM;
            {mem[THR_T + 10'd2], mem[THR_T + 10'd3]} <= `MMW_TEMP_LO_ALM;
            {mem[THR_T + 10'd4], mem[THR_T + 10'd5]} <= `MMW_TEMP_HI_WRN;
            {mem[THR_T + 10'd6], mem[THR_T + 10'd7]} <= `MMW_TEMP_LO_WRN;
            {mem[THR_V],         mem[THR_V + 10'd1]} <= `MMW_VCC_HI_ALM;
            {mem[THR_V + 10'd2], mem[THR_V + 10'd3]} <= `MMW_VCC_LO_ALM;
            {mem[THR_V + 10'd4], mem[THR_V + 10'd5]} <= `MMW_VCC_HI_WRN;
            {mem[THR_V + 10'd6], mem[THR_V + 10'd7]} <= `MMW_VCC_LO_WRN;
        end else if (mem_we) begin
            mem[mem_index(page_q, ptr_q)] <= rx_byte;
        end
    end

    // Output stays released until the link register has taken a known value
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            oe_hold_q <= 1'b1;
        end else if (scl_fall) begin
            oe_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_q     <= mmw_pkg::ST_IDLE;
            bit_cnt_q   <= 4'd0;
            drive_low_q <= 1'b0;
            rw_q        <= 1'b0;
            have_ptr_q  <= 1'b0;
            ptr_q       <= 8'h00;
            page_q      <= `MMW_PAGE_RST;
            tx_q        <= 8'h00;
        end else if (bus_start) begin
            state_q     <= mmw_pkg::ST_ADDR;
            bit_cnt_q   <= 4'd0;
            drive_low_q <= 1'b0;
        end else if (bus_stop) begin
            state_q     <= mmw_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
        end else if (byte_end) begin
            bit_cnt_q   <= 4'd8;
            drive_low_q <= 1'b0;
            unique case (state_q)
                mmw_pkg::ST_ADDR: begin
                    if (addr_hit) begin
                        drive_low_q <= 1'b1;
                        rw_q        <= rx_byte[0];
                    end else begin
                        state_q <= mmw_pkg::ST_IGNORE;
                    end
                end
                mmw_pkg::ST_WRITE: begin
                    drive_low_q <= 1'b1;
                    have_ptr_q  <= 1'b1;
                    if (!have_ptr_q) begin
                        ptr_q <= rx_byte;
                    end else begin
                        ptr_q <= ptr_q + 8'h01;
                    end
                    if (pg_we) begin
                        page_q <= rx_byte;
                    end
                end
                mmw_pkg::ST_IDLE, mmw_pkg::ST_READ, mmw_pkg::ST_IGNORE: begin
                end
            endcase
        end else if (ack_end) begin
            bit_cnt_q   <= 4'd0;
            drive_low_q <= 1'b0;
            if (rd_load) begin
                state_q     <= mmw_pkg::ST_READ;
                tx_q        <= rd_byte;
                drive_low_q <= ~rd_byte[7];
                ptr_q       <= ptr_q + 8'h01;
            end else if (state_q == mmw_pkg::ST_ADDR) begin
                state_q    <= mmw_pkg::ST_WRITE;
                have_ptr_q <= 1'b0;
            end else if (state_q == mmw_pkg::ST_READ) begin
                // Host did not acknowledge: release the line until the next start
                state_q <= mmw_pkg::ST_IGNORE;
            end
        end else if (scl_rise) begin
            bit_cnt_q   <= bit_cnt_q + 4'd1;
            drive_low_q <= 1'b0;
            if (state_q == mmw_pkg::ST_READ) begin
                tx_q        <= {tx_q[6:0], 1'b0};
                drive_low_q <= ~tx_q[6];
            end
        end
    end

    assign SDA_OUT     = 1'b0;
    assign SDA_OE      = sda_oe_q & ~oe_hold_q;
    assign ATTENTION_N = attn_n_q;

    // Checks
    chk_addr_ack: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        byte_end && !bus_start && !bus_stop && state_q == mmw_pkg::ST_ADDR && addr_hit
        |=> drive_low_q && bit_cnt_q == 4'd8)
        else $error("own address not acknowledged");

    chk_foreign_addr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        byte_end && !bus_start && !bus_stop && state_q == mmw_pkg::ST_ADDR && !addr_hit
        |=> state_q == mmw_pkg::ST_IGNORE && !drive_low_q)
        else $error("foreign address acknowledged");

    chk_thr_protect: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ##1 $stable(mem[THR_T]) && $stable(mem[THR_V + 10'd7]))
        else $error("write-protected threshold changed");

    // Raw pin level: the synchronised copy still reads high just after the fall that moves the bit
    chk_high_stable: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        LINK_SCL && $past(LINK_SCL) && !oe_hold_q |-> $stable(SDA_OE))
        else $error("data output moved while clock high");

    chk_ptr_advance: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        rd_load && !bus_start && !bus_stop |=> ptr_q == $past(ptr_q) + 8'h01
        && state_q == mmw_pkg::ST_READ)
        else $error("address not advanced after read byte");

    chk_page_select: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        pg_we && !bus_start && !bus_stop |=> page_q == $past(rx_byte))
        else $error("page select not taken");

    chk_absent_fill: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        absent && ptr_q != `MMW_PAGE_SEL_ADDR |-> rd_byte == `MMW_FILL_BYTE)
        else $error("absent page did not read fill value");

    chk_flag_attn: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        flag_set[7] |=> flag_q[7] && !ATTENTION_N)
        else $error("alarm did not raise attention");

    chk_flag_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        flag_q[4] && !flag_clr[4] |=> flag_q[4] ##1 (flag_q[4] || $past(flag_clr[4])))
        else $error("flag lost without a read");

    chk_stop_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        bus_stop |=> state_q == mmw_pkg::ST_IDLE && !drive_low_q)
        else $error("stop did not end the transfer");

    chk_live_temp: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ptr_q == `MMW_MON_TEMP |-> rd_byte == TEMP_MON[15:8])
        else $error("temperature reading not live");

endmodule // mmw_target

// >>> mmw_host.sv
// Host-side two-wire controller model that drives the serial clock and pulls the data line
`timescale 1ns/1ps
module mmw_host (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // A bit lasts four quarters, 32 ns; every fifth quarter edge lands on a system clock edge
    localparam int Q = 8;

    // Clock stands high and data is released between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // Start and repeated start: data falls while the clock is high
    task automatic start();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #Q;
    endtask

    // Data changes only while the clock is low
    task automatic bit_out(input logic b);
        sda_pull = ~b;
        #Q scl = 1'b1;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask

    task automatic bit_in(output logic b);
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q b = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = ~b;
    endtask

    task automatic byte_in(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(~ack);
    endtask
endmodule // mmw_host

// >>> tb.sv
// Self-checking bench for the two-wire management target
`timescale 1ns/1ps
`include "mmw_defs.svh"
module tb;
    logic        clock;
    logic        sys_rst;
    logic [15:0] temp_mon;
    logic [15:0] vcc_mon;
    logic [63:0] rx_power;
    logic [63:0] tx_bias;
    logic [63:0] tx_power;
    wire logic   scl;
    wire logic   sda_pull;
    wire logic   sda_out;
    wire logic   sda_oe;
    wire logic   attention_n;
    wire logic   sda_w;
    logic [7:0]  got [8];
    int          err_total;
    int          n_tests;

    // Open drain: either party pulls low, otherwise the pull-up wins
    assign sda_w = sda_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);

    mmw_target dut (.CLOCK(clock), .SYS_RST(sys_rst), .LINK_SCL(scl), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TEMP_MON(temp_mon), .VCC_MON(vcc_mon),
        .RX_POWER(rx_power), .TX_BIAS(tx_bias), .TX_POWER(tx_power),
        .ATTENTION_N(attention_n));
    mmw_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] b);
        logic a;
        host.byte_out(b, a);
        chk("ack", 8'h01, {7'h00, a});
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
        host.start();
        send({`MMW_TGT_ADDR, 1'b0});
        send(ptr);
        for (int i = 0; i < n; i++) send(d[15-8*i -: 8]);
        host.stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input int n);
        host.start();
        send({`MMW_TGT_ADDR, 1'b0});
        send(ptr);
        host.start();
        send({`MMW_TGT_ADDR, 1'b1});
        for (int i = 0; i < n; i++) host.byte_in(i < n - 1, got[i]);
        host.stop();
    endtask

    // Returned data may only move while the serial clock is low
    always @(sda_oe) begin
        if (!sys_rst && scl === 1'b1) begin
            err_total++;
            $display("MISMATCH sda_oe edge expected clock low seen clock high");
        end
    end

    task automatic t_reset();
        chk("attention_n idle", 8'h01, {7'h00, attention_n});
        chk("sda_oe idle", 8'h00, {7'h00, sda_oe});
        rd(`MMW_PAGE_SEL_ADDR, 1);
        chk("page select reset", `MMW_PAGE_RST, got[0]);
    endtask

    task automatic t_addr();
        logic a;
        host.start();
        host.byte_out({7'h51, 1'b0}, a);
        chk("ack other address", 8'h00, {7'h00, a});
        host.stop();
    endtask

    // First byte lands below the writable span and is dropped, pointer still moves
    task automatic t_lower();
        wr(8'h55, 16'h1122, 2);
        rd(8'h55, 3);
        chk("lower 55", 8'h00, got[0]);
        chk("lower 56", 8'h22, got[1]);
        chk("lower 57", 8'h00, got[2]);
    endtask

    task automatic t_pages();
        logic [63:0] thr [2];
        logic [7:0]  tad [2];
        thr[0] = {`MMW_TEMP_HI_ALM, `MMW_TEMP_LO_ALM, `MMW_TEMP_HI_WRN, `MMW_TEMP_LO_WRN};
        thr[1] = {`MMW_VCC_HI_ALM, `MMW_VCC_LO_ALM, `MMW_VCC_HI_WRN, `MMW_VCC_LO_WRN};
        tad[0] = `MMW_THR_TEMP;
        tad[1] = `MMW_THR_VCC;
        wr(`MMW_PAGE_SEL_ADDR, 16'h0300, 1);
        for (int k = 0; k < 2; k++) begin
            rd(tad[k], 8);
            for (int i = 0; i < 8; i++) chk("threshold", thr[k][63-8*i -: 8], got[i]);
        end
        wr(`MMW_THR_TEMP, 16'h5500, 1);
        rd(`MMW_THR_TEMP, 1);
        chk("protected threshold", thr[0][63:56], got[0]);
        wr(`MMW_PAGE_SEL_ADDR, 16'h0200, 1);
        wr(8'h80, 16'h3cc3, 2);
        rd(8'h80, 2);
        chk("user page 80", 8'h3c, got[0]);
        chk("user page 81", 8'hc3, got[1]);
        // Page 06 aliases the page 02 storage, so a missing fill would show 3c here
        wr(`MMW_PAGE_SEL_ADDR, 16'h0600, 1);
        rd(8'h80, 1);
        chk("absent page", `MMW_FILL_BYTE, got[0]);
    endtask

    task automatic t_live();
        logic [7:0]  ma [5];
        logic [15:0] mv [5];
        ma = '{`MMW_MON_TEMP, `MMW_MON_VCC, `MMW_MON_RXP, `MMW_MON_BIAS, `MMW_MON_TXP};
        mv = '{16'h1234, 16'h8123, 16'habcd, 16'h0102, 16'h0304};
        for (int i = 0; i < 5; i++) begin
            rd(ma[i], 2);
            chk("monitor msb", mv[i][15:8], got[0]);
            chk("monitor lsb", mv[i][7:0], got[1]);
        end
    endtask

    // Each entry pushes one monitor out of range, restores it, then reads the sticky flags
    task automatic t_flags();
        logic [15:0] tt [3];
        logic [15:0] vv [3];
        logic [7:0]  fa [3];
        logic [7:0]  fe [3];
        tt = '{16'h4c00, 16'hfa00, 16'h1234};
        vv = '{16'h8123, 16'h8123, 16'h9000};
        fa = '{`MMW_FLAG_TEMP, `MMW_FLAG_TEMP, `MMW_FLAG_VCC};
        fe = '{8'ha0, 8'h50, 8'ha0};
        for (int i = 0; i < 3; i++) begin
            @(negedge clock);
            temp_mon = tt[i];
            vcc_mon = vv[i];
            for (int k = 0; k < 20 && attention_n !== 1'b0; k++) @(negedge clock);
            chk("attention_n low", 8'h00, {7'h00, attention_n});
            temp_mon = 16'h1234;
            vcc_mon = 16'h8123;
            rd(fa[i], 1);
            chk("flag byte", fe[i], got[0] & 8'hf0);
            rd(fa[i], 1);
            chk("flag cleared", 8'h00, got[0] & 8'hf0);
            repeat (4) @(negedge clock);
            chk("attention_n high", 8'h01, {7'h00, attention_n});
        end
    endtask

    initial begin
        #200000;
        err_total++;
        $display("MISMATCH watchdog expected done seen timeout");
        close_out();
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        temp_mon = 16'h1234;
        vcc_mon = 16'h8123;
        rx_power = {4{16'habcd}};
        tx_bias = {4{16'h0102}};
        tx_power = {4{16'h0304}};
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        t_reset();
        t_addr();
        t_lower();
        t_pages();
        t_live();
        t_flags();
        close_out();
    end
endmodule // tb
